// File: core/avalon_slave_port.sv
`timescale 1ns/1ps
module avalon_slave_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [usb_state_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [usb_state_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [usb_state_pkg::BE_W-1:0] avs_byteenable,
  output logic [usb_state_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Register side
  reg_access_if.bus_side regs
);

  usb_state_pkg::bus_state_t state_r;
  usb_state_pkg::bus_state_t state_nxt;
  logic [usb_state_pkg::DATA_W-1:0] readdata_r;
  wire req = avs_read | avs_write;
  wire answering = (state_r == usb_state_pkg::BUS_ANSWER);

  // One wait state gives the register mux a full cycle before data stands
  assign avs_waitrequest = req & ~answering;
  assign regs.rd_stb = avs_read & ~answering;
  assign regs.wr_stb = avs_write & answering;
  assign regs.addr = avs_address;
  assign regs.wdata = avs_writedata;
  assign regs.be = avs_byteenable;
  assign avs_readdata = readdata_r;

  // Phase sequencing
  always_comb begin
    case (state_r)
      usb_state_pkg::BUS_IDLE: begin
        state_nxt = req ? usb_state_pkg::BUS_ANSWER : usb_state_pkg::BUS_IDLE;
      end
      usb_state_pkg::BUS_ANSWER: begin
        state_nxt = usb_state_pkg::BUS_IDLE;
      end
      default: begin
        state_nxt = usb_state_pkg::BUS_IDLE;
      end
    endcase
  end

  // Phase register and read data capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= usb_state_pkg::BUS_IDLE;
      readdata_r <= usb_state_pkg::READ_ZERO;
    end else begin
      state_r <= state_nxt;
      if (regs.rd_stb) begin
        readdata_r <= regs.rdata;
      end
    end
  end

endmodule : avalon_slave_port

// File: core/reg_access_if.sv
`timescale 1ns/1ps
// Register access strobes between the bus slave and the register file
interface reg_access_if;
  logic wr_stb;
  logic rd_stb;
  logic [usb_state_pkg::ADDR_W-1:0] addr;
  logic [usb_state_pkg::DATA_W-1:0] wdata;
  logic [usb_state_pkg::BE_W-1:0] be;
  logic [usb_state_pkg::DATA_W-1:0] rdata;

  modport bus_side (
    output wr_stb,
    output rd_stb,
    output addr,
    output wdata,
    output be,
    input rdata
  );

  modport reg_side (
    input wr_stb,
    input rd_stb,
    input addr,
    input wdata,
    input be,
    output rdata
  );
endinterface : reg_access_if

// File: core/usb_device_state_tracker.sv
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module usb_device_state_tracker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [usb_state_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [usb_state_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [usb_state_pkg::BE_W-1:0] avs_byteenable,
  output logic [usb_state_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Bus reset seen on the USB link
  input wire logic usb_bus_reset,
  // Device state towards the link logic
  output logic address_state,
  output logic configured_state,
  output logic [usb_state_pkg::FADDR_W-1:0] function_address_value,
  output logic function_enable
);

  reg_access_if regs ();

  logic address_state_flag_r;
  logic address_state_flag_nxt;
  logic configured_flag_r;
  logic configured_flag_nxt;
  logic [usb_state_pkg::FADDR_W-1:0] function_address_r;
  logic [usb_state_pkg::FADDR_W-1:0] function_address_nxt;
  logic function_enable_r;
  logic function_enable_nxt;

  // Bus slave turns Avalon cycles into single-cycle strobes
  avalon_slave_port u_bus (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .regs(regs)
  );

  // Address decode; unmapped offsets read zero and ignore writes
  wire hit_state = (regs.addr == usb_state_pkg::OFS_DEVICE_STATE);
  wire hit_faddr = (regs.addr == usb_state_pkg::OFS_FUNCTION_ADDRESS);
  wire lane_flags = regs.be[usb_state_pkg::LANE_FLAGS];
  wire lane_enable = regs.be[usb_state_pkg::LANE_ENABLE];
  wire wr_state = regs.wr_stb & hit_state & lane_flags;
  wire wr_faddr = regs.wr_stb & hit_faddr & lane_flags;
  wire wr_fen = regs.wr_stb & hit_faddr & lane_enable;
  wire set_address = regs.wdata[usb_state_pkg::BIT_ADDRESS_STATE];
  wire set_configured = regs.wdata[usb_state_pkg::BIT_CONFIGURED];

  // Address flag is set-only from software; a bus reset wins over a write
  assign address_state_flag_nxt = usb_bus_reset
    ? usb_state_pkg::ADDRESS_STATE_RESET
    : (wr_state & set_address) ? 1'b1
    : address_state_flag_r;

  // Configured flag follows the written value in both directions
  assign configured_flag_nxt = usb_bus_reset ? usb_state_pkg::CONFIGURED_RESET
    : wr_state ? set_configured
    : configured_flag_r;

  // Function address clears on bus reset, like the state flags
  assign function_address_nxt = usb_bus_reset ? usb_state_pkg::FADDR_RESET
    : wr_faddr ? regs.wdata[usb_state_pkg::FADDR_LSB +: usb_state_pkg::FADDR_W]
    : function_address_r;

  // Enable survives bus reset: firmware owns it, and it keeps its value across the host reset
  assign function_enable_nxt = wr_fen
    ? regs.wdata[usb_state_pkg::BIT_FUNCTION_ENABLE] : function_enable_r;

  // Read mux; unused bits are zero
  logic [usb_state_pkg::DATA_W-1:0] state_word;
  logic [usb_state_pkg::DATA_W-1:0] faddr_word;
  always_comb begin
    state_word = usb_state_pkg::READ_ZERO;
    state_word[usb_state_pkg::BIT_ADDRESS_STATE] = address_state_flag_r;
    state_word[usb_state_pkg::BIT_CONFIGURED] = configured_flag_r;
    faddr_word = usb_state_pkg::READ_ZERO;
    faddr_word[usb_state_pkg::FADDR_LSB +: usb_state_pkg::FADDR_W] =
      function_address_r;
    faddr_word[usb_state_pkg::BIT_FUNCTION_ENABLE] = function_enable_r;
  end
  assign regs.rdata = hit_state ? state_word
    : hit_faddr ? faddr_word : usb_state_pkg::READ_ZERO;

  // State registers; system reset leaves the device in default state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_state_flag_r <= usb_state_pkg::ADDRESS_STATE_RESET;
      configured_flag_r <= usb_state_pkg::CONFIGURED_RESET;
      function_address_r <= usb_state_pkg::FADDR_RESET;
      function_enable_r <= usb_state_pkg::FUNCTION_ENABLE_RESET;
    end else begin
      address_state_flag_r <= address_state_flag_nxt;
      configured_flag_r <= configured_flag_nxt;
      function_address_r <= function_address_nxt;
      function_enable_r <= function_enable_nxt;
    end
  end

  // Outputs to the link side straight from flops
  assign address_state = address_state_flag_r;
  assign configured_state = configured_flag_r;
  assign function_address_value = function_address_r;
  assign function_enable = function_enable_r;

  // Checks on the state register behaviour

  sequence s_state_read;
    regs.rd_stb && hit_state;
  endsequence

  sequence s_set_address;
    wr_state && set_address && !usb_bus_reset;
  endsequence

  sequence s_clear_address_attempt;
    wr_state && !set_address && !usb_bus_reset;
  endsequence

  property p_address_set;
    @(posedge sys_clk) disable iff (!rst_n)
    s_set_address |=> address_state_flag_r;
  endproperty
  a_address_set: assert property (p_address_set)
    else $error("address flag not set by write of one");

  property p_address_zero_no_effect;
    @(posedge sys_clk) disable iff (!rst_n)
    s_clear_address_attempt |=> $stable(address_state_flag_r);
  endproperty
  a_address_zero_no_effect: assert property (p_address_zero_no_effect)
    else $error("address flag changed by write of zero");

  property p_address_leaves_only_by_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    address_state_flag_r && !usb_bus_reset |=> address_state_flag_r;
  endproperty
  a_address_leaves_only_by_reset:
    assert property (p_address_leaves_only_by_reset)
    else $error("address flag dropped without reset");

  property p_read_address_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    s_state_read |=> avs_readdata[usb_state_pkg::BIT_ADDRESS_STATE]
      == $past(address_state_flag_r);
  endproperty
  a_read_address_flag: assert property (p_read_address_flag)
    else $error("read of address flag wrong");

  property p_read_configured_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    s_state_read |=> avs_readdata[usb_state_pkg::BIT_CONFIGURED]
      == $past(configured_flag_r);
  endproperty
  a_read_configured_flag: assert property (p_read_configured_flag)
    else $error("read of configured flag wrong");

  property p_read_other_bits_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    s_state_read |=>
      avs_readdata[usb_state_pkg::DATA_W-1:usb_state_pkg::BIT_CONFIGURED+1]
      == 30'h0;
  endproperty
  a_read_other_bits_zero: assert property (p_read_other_bits_zero)
    else $error("unused state bits read nonzero");

  property p_configured_write;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_state && !usb_bus_reset |=>
      configured_flag_r == $past(set_configured);
  endproperty
  a_configured_write: assert property (p_configured_write)
    else $error("configured flag does not follow write");

  property p_bus_reset_clears;
    @(posedge sys_clk) disable iff (!rst_n)
    usb_bus_reset |=> !address_state_flag_r && !configured_flag_r
      && function_address_r == usb_state_pkg::FADDR_RESET;
  endproperty
  a_bus_reset_clears: assert property (p_bus_reset_clears)
    else $error("bus reset left state behind");

  property p_faddr_write;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_faddr && !usb_bus_reset |=> function_address_r
      == $past(regs.wdata[usb_state_pkg::FADDR_W-1:0]);
  endproperty
  a_faddr_write: assert property (p_faddr_write)
    else $error("function address not stored");

  property p_write_needs_answer;
    @(posedge sys_clk) disable iff (!rst_n)
    avs_write && avs_waitrequest |=> !avs_waitrequest || !avs_write;
  endproperty
  a_write_needs_answer: assert property (p_write_needs_answer)
    else $error("write not answered within one wait state");

  property p_read_needs_answer;
    @(posedge sys_clk) disable iff (!rst_n)
    avs_read && avs_waitrequest |=> !avs_waitrequest || !avs_read;
  endproperty
  a_read_needs_answer: assert property (p_read_needs_answer)
    else $error("read not answered within one wait state");

  // Read data must stand until the next read is taken
  property p_readdata_stands;
    @(posedge sys_clk) disable iff (!rst_n)
    !regs.rd_stb |=> $stable(avs_readdata);
  endproperty
  a_readdata_stands: assert property (p_readdata_stands)
    else $error("read data moved without a read");

  property p_unmapped_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    regs.rd_stb && !hit_state && !hit_faddr |=>
      avs_readdata == usb_state_pkg::READ_ZERO;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero");

  property p_configured_set;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_state && set_configured && !usb_bus_reset |=> configured_flag_r;
  endproperty
  a_configured_set: assert property (p_configured_set)
    else $error("configured flag not set by write of one");

  property p_configured_clear;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_state && !set_configured && !usb_bus_reset |=> !configured_flag_r;
  endproperty
  a_configured_clear: assert property (p_configured_clear)
    else $error("configured flag not cleared by write of zero");

  // Without a write or a bus reset the configured flag must hold
  property p_configured_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !wr_state && !usb_bus_reset |=> $stable(configured_flag_r);
  endproperty
  a_configured_hold: assert property (p_configured_hold)
    else $error("configured flag moved without a write");

  // A write with the flag lane masked off must leave both flags
  property p_masked_write;
    @(posedge sys_clk) disable iff (!rst_n)
    regs.wr_stb && hit_state && !lane_flags && !usb_bus_reset |=>
      $stable(address_state_flag_r) && $stable(configured_flag_r);
  endproperty
  a_masked_write: assert property (p_masked_write)
    else $error("masked write changed a state flag");

  property p_address_set_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !address_state_flag_r && !(wr_state && set_address) |=>
      !address_state_flag_r;
  endproperty
  a_address_set_hold: assert property (p_address_set_hold)
    else $error("address flag set without a write of one");

  // Host reset wins over a write landing in the same cycle
  property p_bus_reset_wins;
    @(posedge sys_clk) disable iff (!rst_n)
    usb_bus_reset && wr_state |=>
      !address_state_flag_r && !configured_flag_r;
  endproperty
  a_bus_reset_wins: assert property (p_bus_reset_wins)
    else $error("write won over bus reset");

  property p_read_faddr;
    @(posedge sys_clk) disable iff (!rst_n)
    regs.rd_stb && hit_faddr |=> avs_readdata[usb_state_pkg::FADDR_LSB
      +: usb_state_pkg::FADDR_W] == $past(function_address_r);
  endproperty
  a_read_faddr: assert property (p_read_faddr)
    else $error("read of function address wrong");

  property p_read_enable;
    @(posedge sys_clk) disable iff (!rst_n)
    regs.rd_stb && hit_faddr |=>
      avs_readdata[usb_state_pkg::BIT_FUNCTION_ENABLE]
      == $past(function_enable_r);
  endproperty
  a_read_enable: assert property (p_read_enable)
    else $error("read of function enable wrong");

  property p_faddr_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !wr_faddr && !usb_bus_reset |=> $stable(function_address_r);
  endproperty
  a_faddr_hold: assert property (p_faddr_hold)
    else $error("function address moved without a write");

  // Firmware owns the enable, so a host reset must not touch it
  property p_enable_survives;
    @(posedge sys_clk) disable iff (!rst_n)
    usb_bus_reset && !wr_fen |=> $stable(function_enable_r);
  endproperty
  a_enable_survives: assert property (p_enable_survives)
    else $error("function enable changed by bus reset");

  // Request phase, then answer phase, then the flag stands
  sequence s_address_write_req;
    avs_write && avs_waitrequest && hit_state && lane_flags && set_address;
  endsequence

  sequence s_write_answer;
    avs_write && !avs_waitrequest && hit_state && !usb_bus_reset;
  endsequence

  property p_address_write_lands;
    @(posedge sys_clk) disable iff (!rst_n)
    s_address_write_req ##1 s_write_answer |=> address_state_flag_r;
  endproperty
  a_address_write_lands: assert property (p_address_write_lands)
    else $error("address write did not land after its answer");

endmodule : usb_device_state_tracker

// File: core/usb_state_pkg.sv
// What this block does
// - One register lets software read and write the USB device state.
// - Bit 0 of the state register reads 1 in address state and 0 otherwise.
// - Writing 0 to bit 0 does nothing; only a reset leaves address state.
// - Writing 1 to bit 0 puts the device in address state.
// - Bit 1 of the state register reads 1 in configured state and 0 otherwise.
// - Writing 0 to bit 1 leaves configured state and writing 1 enters it.
// - The function address register holds 7 address bits, reset to zero.
package usb_state_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Byte offsets of the registers
  localparam logic [7:0] OFS_DEVICE_STATE = 8'h04;
  localparam logic [7:0] OFS_FUNCTION_ADDRESS = 8'h08;

  // Field positions in the device state register
  localparam int BIT_ADDRESS_STATE = 0;
  localparam int BIT_CONFIGURED = 1;

  // Field positions in the function address register
  localparam int FADDR_LSB = 0;
  localparam int FADDR_W = 7;
  localparam int BIT_FUNCTION_ENABLE = 8;

  // Byte lanes that carry the fields
  localparam int LANE_FLAGS = 0;
  localparam int LANE_ENABLE = 1;

  // Reset values
  localparam logic ADDRESS_STATE_RESET = 1'b0;
  localparam logic CONFIGURED_RESET = 1'b0;
  localparam logic [6:0] FADDR_RESET = 7'h00;
  localparam logic FUNCTION_ENABLE_RESET = 1'b1;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Bus slave phases
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage : usb_state_pkg

// File: tb/usb_device_state_tracker_tb.sv
`timescale 1ns/1ps
module usb_device_state_tracker_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic usb_bus_reset;
  logic address_state;
  logic configured_state;
  logic [6:0] function_address_value;
  logic function_enable;
  logic [31:0] rd;
  int error_cnt = 0;
  int cmp_count = 0;

  usb_device_state_tracker dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .usb_bus_reset(usb_bus_reset), .address_state(address_state),
    .configured_state(configured_state),
    .function_address_value(function_address_value),
    .function_enable(function_enable)
  );

  usb_host_model host (
    .sys_clk(sys_clk),
    .usb_bus_reset(usb_bus_reset)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Compare a value against its expectation
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Hold the request until waitrequest is sampled low; bounded wait
  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      $display("[ERR] waitrequest expected 0 seen stuck");
      complete_run();
    end
  endtask : bus_xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 32'h0, 4'hf);
    check($sformatf("reg %h", a), exp, rd);
  endtask : rd_chk

  // Let the write land, then look at the state pins
  task automatic pins_chk(input logic [9:0] exp);
    @(posedge sys_clk);
    #1;
    check("pins", {22'h0, exp}, {22'h0, function_enable, address_state,
          configured_state, function_address_value});
  endtask : pins_chk

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0100);
    pins_chk(10'h200);
    $display("test reset_values done");
    // Enumeration: address first, flag after the status stage
    bus_xfer(1'b1, 8'h08, 32'h0000_012a, 4'h3);
    rd_chk(8'h08, 32'h0000_012a);
    bus_xfer(1'b1, 8'h04, 32'h0000_0001, 4'h1);
    rd_chk(8'h04, 32'h0000_0001);
    pins_chk(10'h32a);
    bus_xfer(1'b1, 8'h04, 32'h0000_0003, 4'h1);
    rd_chk(8'h04, 32'h0000_0003);
    pins_chk(10'h3aa);
    $display("test enumeration done");
    // Writing zeros keeps address state, drops configured
    bus_xfer(1'b1, 8'h04, 32'h0000_0000, 4'hf);
    rd_chk(8'h04, 32'h0000_0001);
    bus_xfer(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
    rd_chk(8'h04, 32'h0000_0003);
    bus_xfer(1'b1, 8'h04, 32'h0000_0000, 4'h0);
    rd_chk(8'h04, 32'h0000_0003);
    $display("test flag_writes done");
    // Unmapped place reads zero and swallows writes
    bus_xfer(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
    rd_chk(8'h0c, 32'h0000_0000);
    rd_chk(8'h04, 32'h0000_0003);
    $display("test unmapped done");
    // Bus reset from the host returns to default state
    host.bus_reset(1);
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0100);
    pins_chk(10'h200);
    // A write answered while the host holds reset is lost
    bus_xfer(1'b1, 8'h04, 32'h0000_0003, 4'h1);
    fork
      host.bus_reset(2);
      bus_xfer(1'b1, 8'h04, 32'h0000_0003, 4'h1);
    join
    rd_chk(8'h04, 32'h0000_0000);
    $display("test bus_reset done");
    // Second system reset in mid-run
    bus_xfer(1'b1, 8'h04, 32'h0000_0003, 4'h1);
    bus_xfer(1'b1, 8'h08, 32'h0000_007f, 4'h3);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0100);
    $display("test mid_reset done");
    complete_run();
  end
endmodule : usb_device_state_tracker_tb

// File: tb/usb_host_model.sv
`timescale 1ns/1ps
// Far-side host: only the bus reset of enumeration reaches this block
module usb_host_model (
  // Clock
  input wire logic sys_clk,
  // Link towards the device
  output logic usb_bus_reset
);
  initial usb_bus_reset = 1'b0;

  // Drive a bus reset for n cycles; besides a system reset on rst_n, the only way back to default state
  task automatic bus_reset(input int n);
    @(posedge sys_clk);
    usb_bus_reset <= 1'b1;
    repeat (n) @(posedge sys_clk);
    usb_bus_reset <= 1'b0;
  endtask : bus_reset
endmodule : usb_host_model
